// ### modulation_setting_registers.sv
/*
 * Modulation setting register bank: auxiliary modulation and passive target
 * modulation registers, plus a copy of the transmit driver register that
 * supplies the amplitude index. Outputs feed the analog driver and the
 * external load-modulation pin.
 * Assumes synchronous inputs, one clock, synchronous active-high reset and a
 * master that never issues read and write strobes together.
 */
// Implementation choice: the plain strobed port.
// Overview of operation
// [RL1] Bit 7 low enables regulator amplitude modulation; high disables it.
// [RL2] Regulator modulation uses the four-bit index from the transmit driver register.
// [RL3] Bit 6 low drives the external pin active high, high drives it active low.
// [RL4] External pin carries load modulation only while bit 5 is set.
// [RL5] Bit 4, reset one, enables driver load modulation using target resistances.
// [RL6] Bit 3 enables resistive modulation using the seven-bit modulated level.
// [RL7] Bit 2 enables shaped regulator modulation for active wave shaping.
// [RL8] Software should clear bit 2 in card, wake-up and transmitter-off measurements.
// [RL9] Modulated passive state uses resistance field bits 7 to 4, reset seven.
// [RL10] Unmodulated passive state uses resistance field bits 3 to 0, reset zero.
// [RL11] Software writes both resistance fields before selecting passive target mode.
// [RL12] Codes 0 to 14 rise in resistance; code 15 means high impedance.
// [RL13] Auxiliary register bits 1 and 0 read zero and ignore writes.
// [RL14] Space select decides whether offset 0x28 hits auxiliary or transmit driver.
module modulation_setting_registers (
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire logic                     ce,
   input  wire logic                     reg_space,
   input  wire logic [7:0]               reg_addr,
   input  wire logic [7:0]               reg_wdata,
   input  wire logic                     reg_wr,
   input  wire logic                     reg_rd,
   input  wire logic [6:0]               resistive_modulated_level,
   input  wire logic                     loadmod_active,
   output logic [7:0]                    reg_rdata,
   output modulation_pkg::mod_ctrl_t     mod_ctrl,
   output logic                          external_loadmod_pin
);

   modulation_pkg::reg_req_t req;
   logic [7:0]               aux_reg;
   logic [7:0]               pt_reg;
   logic [7:0]               tx_reg;
   logic [7:0]               next_aux_reg;
   logic [7:0]               next_pt_reg;
   logic [7:0]               next_tx_reg;
   logic [7:0]               next_rdata;
   logic [3:0]               sel_res;
   logic                     sel_high_z;
   modulation_pkg::mod_ctrl_t next_mod_ctrl;
   logic                     next_ext_pin;

   typedef enum logic [2:0] {
      SEL_NONE = 3'b001,
      SEL_AUX  = 3'b010,
      SEL_PT   = 3'b100
   } hit_t;

   // Bundle the strobe port so decode sees one request.
   assign req = '{space: reg_space, addr: reg_addr, wdata: reg_wdata,
                  wr: reg_wr, rd: reg_rd};

   // Decoding is shared by the read and write paths, so it lives in a function.
   function automatic hit_t decode(input logic space, input logic [7:0] addr);
      hit_t h;
      h = SEL_NONE;
      if (space == modulation_pkg::SPACE_SECONDARY && addr == modulation_pkg::AUX_MOD_OFFSET) begin
         h = SEL_AUX; // see [RL14]
      end else if (space == modulation_pkg::SPACE_PRIMARY &&
                   addr == modulation_pkg::PT_MOD_OFFSET) begin
         h = SEL_PT;
      end
      return h;
   endfunction

   // The transmit driver copy sits in the primary space at the same offset.
   function automatic logic tx_hit(input logic space, input logic [7:0] addr);
      return space == modulation_pkg::SPACE_PRIMARY &&
             addr == modulation_pkg::TX_DRIVER_OFFSET; // see [RL14]
   endfunction

   // Register write path; reserved low bits of the auxiliary register never store.
   always_comb begin
      next_aux_reg = aux_reg;
      next_pt_reg  = pt_reg;
      next_tx_reg  = tx_reg;
      if (req.wr) begin
         case (decode(req.space, req.addr))
            SEL_AUX: begin
               next_aux_reg = req.wdata & modulation_pkg::AUX_WRITABLE_MASK; // see [RL13]
            end
            SEL_PT: begin
               next_pt_reg = req.wdata;
            end
            SEL_NONE: begin
               if (tx_hit(req.space, req.addr)) begin
                  next_tx_reg = req.wdata;
               end
            end
            default: begin
               next_aux_reg = aux_reg;
            end
         endcase
      end
   end

   // Read path; data appears in the cycle after the read strobe only.
   always_comb begin
      next_rdata = modulation_pkg::UNMAPPED_READ;
      if (req.rd) begin
         case (decode(req.space, req.addr))
            SEL_AUX: begin
               next_rdata = aux_reg & modulation_pkg::AUX_WRITABLE_MASK; // see [RL13]
            end
            SEL_PT: begin
               next_rdata = pt_reg;
            end
            SEL_NONE: begin
               if (tx_hit(req.space, req.addr)) begin
                  next_rdata = tx_reg;
               end
            end
            default: begin
               next_rdata = modulation_pkg::UNMAPPED_READ;
            end
         endcase
      end
   end

   resistance_select u_res_sel (
      .driver_loadmod_enable (aux_reg[modulation_pkg::DRV_LM_BIT]),
      .loadmod_active        (loadmod_active),
      .pt_reg                (pt_reg),
      .res_code              (sel_res),
      .high_z                (sel_high_z)
   );

   // Decode control bits into driver controls; registered so outputs are glitch free.
   always_comb begin
      next_mod_ctrl.regulator_am_on = ~aux_reg[modulation_pkg::REG_AM_OFF_BIT]; // see [RL1]
      next_mod_ctrl.amplitude_index_field =
         next_mod_ctrl.regulator_am_on ? tx_reg[modulation_pkg::AM_INDEX_LSB +: 4] : 4'h0; // see [RL2]
      next_mod_ctrl.resistive_amplitude_enable = aux_reg[modulation_pkg::RESISTIVE_AMPLITUDE_ENABLE_BIT]; // see [RL6]
      next_mod_ctrl.resistive_modulated_level =
         aux_reg[modulation_pkg::RESISTIVE_AMPLITUDE_ENABLE_BIT] ? resistive_modulated_level : 7'h00; // see [RL6]
      next_mod_ctrl.shaped_regulator_modulation_enable =
         aux_reg[modulation_pkg::SHAPED_AM_BIT]; // see [RL7]
      next_mod_ctrl.driver_loadmod_enable = aux_reg[modulation_pkg::DRV_LM_BIT]; // see [RL5]
      next_mod_ctrl.rf_output_driver_res = sel_res; // see [RL5]
      next_mod_ctrl.rf_output_driver_high_z = sel_high_z; // see [RL12]
      // Idle pin level follows polarity so the inactive state is never mistaken.
      next_ext_pin = (aux_reg[modulation_pkg::EXT_EN_BIT] & loadmod_active) // see [RL4]
                     ^ aux_reg[modulation_pkg::EXT_POL_BIT]; // see [RL3]
   end

   // All state registers here; clock enable freezes everything except reset, which acts whatever ce is.
   always_ff @(posedge clk) begin
      if (rst) begin
         aux_reg              <= modulation_pkg::AUX_MOD_RESET;
         pt_reg               <= modulation_pkg::PT_MOD_RESET; // see [RL9]
         tx_reg               <= modulation_pkg::TX_DRIVER_RESET;
         reg_rdata            <= modulation_pkg::UNMAPPED_READ;
         mod_ctrl             <= '0;
         external_loadmod_pin <= 1'b0;
      end else if (ce) begin
         aux_reg              <= next_aux_reg;
         pt_reg               <= next_pt_reg;
         tx_reg               <= next_tx_reg;
         reg_rdata            <= next_rdata;
         mod_ctrl             <= next_mod_ctrl;
         external_loadmod_pin <= next_ext_pin;
      end
   end

   // Checks on the register and control behaviour.
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   reg_am_inverted_a: assert property (ce |=> mod_ctrl.regulator_am_on == !$past(aux_reg[7])) // see [RL1]
      else $error("Regulator modulation enable does not follow inverted bit.");
   am_index_source_a: assert property (ce && !aux_reg[7] |=> // see [RL2]
      mod_ctrl.amplitude_index_field == $past(tx_reg[7:4]))
      else $error("Amplitude index not taken from transmit driver register.");
   ext_pin_polarity_a: assert property (ce && !aux_reg[5] |=> external_loadmod_pin == $past(aux_reg[6])) // see [RL3]
      else $error("External pin idle level does not match polarity.");
   ext_pin_enable_a: assert property (ce && aux_reg[5] && loadmod_active && !aux_reg[6] // see [RL4]
      |=> external_loadmod_pin)
      else $error("External pin not driven while enabled.");
   driver_lm_reset_a: assert property ($past(rst) |-> aux_reg[4] && pt_reg == 8'h70) // see [RL5]
      else $error("Driver load modulation reset value wrong.");
   resistive_am_a: assert property (ce |=> mod_ctrl.resistive_amplitude_enable == $past(aux_reg[3])) // see [RL6]
      else $error("Resistive modulation enable wrong.");
   shaped_am_a: assert property (ce |=> // see [RL7]
      mod_ctrl.shaped_regulator_modulation_enable == $past(aux_reg[2]))
      else $error("Shaped regulator modulation enable wrong.");
   modulated_res_a: assert property (ce && aux_reg[4] && loadmod_active |=> // see [RL9]
      mod_ctrl.rf_output_driver_res == $past(pt_reg[7:4]))
      else $error("Modulated state resistance wrong.");
   unmodulated_res_a: assert property (ce && !loadmod_active |=> // see [RL10]
      mod_ctrl.rf_output_driver_res == $past(pt_reg[3:0]))
      else $error("Unmodulated state resistance wrong.");
   high_z_code_a: assert property (mod_ctrl.rf_output_driver_high_z == // see [RL12]
      (mod_ctrl.rf_output_driver_res == 4'hF))
      else $error("High impedance flag disagrees with code.");
   reserved_bits_a: assert property (aux_reg[1:0] == 2'b00) // see [RL13]
      else $error("Reserved bits stored a value.");
   space_decode_a: assert property (ce && reg_wr && reg_space && reg_addr == 8'h28 // see [RL14]
      |=> tx_reg == $past(tx_reg))
      else $error("Secondary space write reached transmit driver register.");

   aux_write_c: cover property (ce && reg_wr && reg_space && reg_addr == 8'h28);
   pt_read_c: cover property (ce && reg_rd && !reg_space && reg_addr == 8'h29 ##1 reg_rdata != 8'h00);
   ext_pin_inverse_c: cover property (aux_reg[5] && aux_reg[6] && loadmod_active);
   high_z_c: cover property (mod_ctrl.rf_output_driver_high_z);

endmodule

// ### modulation_pkg.sv
/*
 * Shared constants and carrier types for the modulation setting register bank.
 * Assumes a single 50 MHz clock domain and a plain strobe-based register port.
 */
package modulation_pkg;

   // Register space select: space 0 is the primary space, space 1 the secondary.
   localparam logic       SPACE_PRIMARY   = 1'b0;
   localparam logic       SPACE_SECONDARY = 1'b1;

   // Offsets within each space.
   localparam logic [7:0] AUX_MOD_OFFSET   = 8'h28;
   localparam logic [7:0] TX_DRIVER_OFFSET = 8'h28;
   localparam logic [7:0] PT_MOD_OFFSET    = 8'h29;

   // Auxiliary modulation register field positions.
   localparam int REG_AM_OFF_BIT   = 7;
   localparam int EXT_POL_BIT      = 6;
   localparam int EXT_EN_BIT       = 5;
   localparam int DRV_LM_BIT       = 4;
   localparam int RESISTIVE_AMPLITUDE_ENABLE_BIT       = 3;
   localparam int SHAPED_AM_BIT    = 2;
   localparam logic [7:0] AUX_WRITABLE_MASK = 8'hFC;

   // Passive target modulation register field positions.
   localparam int PTM_RES_LSB = 4;
   localparam int UNMOD_RES_LSB = 0;

   // Transmit driver register field position of the amplitude index.
   localparam int AM_INDEX_LSB = 4;

   // Reset values.
   localparam logic [7:0] AUX_MOD_RESET   = 8'h10;
   localparam logic [7:0] PT_MOD_RESET    = 8'h70;
   localparam logic [7:0] TX_DRIVER_RESET = 8'h70;

   // Resistance code that puts the driver in high impedance.
   localparam logic [3:0] RES_HIGH_Z_CODE = 4'hF;

   // Read data when the address hits nothing.
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // Register access request from software.
   typedef struct packed {
      logic       space;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

   // Decoded modulation controls toward the analog driver.
   typedef struct packed {
      logic       regulator_am_on;
      logic [3:0] amplitude_index_field;
      logic       resistive_amplitude_enable;
      logic [6:0] resistive_modulated_level;
      logic       shaped_regulator_modulation_enable;
      logic       driver_loadmod_enable;
      logic [3:0] rf_output_driver_res;
      logic       rf_output_driver_high_z;
   } mod_ctrl_t;

endpackage

// ### resistance_select.sv
/*
 * Picks the rf_output_driver resistance code for passive load modulation.
 * Assumes codes follow the shared 16-step encoding where the top code is high Z.
 */
module resistance_select (
   input  wire logic       driver_loadmod_enable,
   input  wire logic       loadmod_active,
   input  wire logic [7:0] pt_reg,
   output logic [3:0]      res_code,
   output logic            high_z
);

   // Modulated state uses the upper field, unmodulated the lower one.
   always_comb begin
      if (driver_loadmod_enable && loadmod_active) begin
         res_code = pt_reg[modulation_pkg::PTM_RES_LSB +: 4]; // see [RL9]
      end else begin
         res_code = pt_reg[modulation_pkg::UNMOD_RES_LSB +: 4]; // see [RL10]
      end
      high_z = (res_code == modulation_pkg::RES_HIGH_Z_CODE); // see [RL12]
   end

endmodule

// ### modulation_setting_registers_test.sv
/*
 * Self-checking bench for the modulation setting register bank.
 * Assumes the design's own assertions guard cycle relations; this bench
 * drives the register port, the load modulation input and reads the controls.
 */
module modulation_setting_registers_test;
   timeunit 1ns;
   timeprecision 1ps;

   `define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin failures++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end

   logic                      clk;
   logic                      rst;
   logic                      ce;
   logic                      reg_space;
   logic [7:0]                reg_addr;
   logic [7:0]                reg_wdata;
   logic                      reg_wr;
   logic                      reg_rd;
   logic [6:0]                res_level;
   logic                      loadmod_active;
   logic [7:0]                reg_rdata;
   modulation_pkg::mod_ctrl_t mc;
   logic                      pin;
   int                        failures;
   int                        tests_run;

   modulation_setting_registers i_dut (
      .clk                       (clk),
      .rst                       (rst),
      .ce                        (ce),
      .reg_space                 (reg_space),
      .reg_addr                  (reg_addr),
      .reg_wdata                 (reg_wdata),
      .reg_wr                    (reg_wr),
      .reg_rd                    (reg_rd),
      .resistive_modulated_level (res_level),
      .loadmod_active            (loadmod_active),
      .reg_rdata                 (reg_rdata),
      .mod_ctrl                  (mc),
      .external_loadmod_pin      (pin)
   );

   // Free running 50 MHz clock.
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // One cycle write strobe, released at the next edge.
   task automatic wr(input logic sp, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_space <= sp;
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so it is sampled there.
   task automatic rd(input logic sp, input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_space <= sp;
      reg_addr  <= a;
      reg_rd    <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // Controls are registered, so two edges cover the one cycle of latency.
   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask

   // Reset values of all three registers and of the decoded controls.
   task automatic t_reset();
      logic [7:0] d;
      settle();
      `CHK("am_on", 1'b1, mc.regulator_am_on)
      `CHK("index", 4'h7, mc.amplitude_index_field)
      `CHK("drv_lm", 1'b1, mc.driver_loadmod_enable)
      `CHK("res", 4'h0, mc.rf_output_driver_res)
      rd(1'b1, 8'h28, d);
      `CHK("aux", 8'h10, d)
      rd(1'b0, 8'h29, d);
      `CHK("pt", 8'h70, d)
      rd(1'b0, 8'h28, d);
      `CHK("tx", 8'h70, d)
   endtask

   // All ones then all zeros exercise every enable and the reserved bits.
   task automatic t_aux();
      logic [7:0] d;
      wr(1'b1, 8'h28, 8'hFF);
      rd(1'b1, 8'h28, d);
      `CHK("aux_ff", 8'hFC, d)
      settle();
      `CHK("am_off", 1'b0, mc.regulator_am_on)
      `CHK("idx_off", 4'h0, mc.amplitude_index_field)
      `CHK("res_on", 1'b1, mc.resistive_amplitude_enable)
      `CHK("lvl", 7'h5A, mc.resistive_modulated_level)
      `CHK("shp_on", 1'b1, mc.shaped_regulator_modulation_enable)
      wr(1'b1, 8'h28, 8'h00);
      wr(1'b0, 8'h28, 8'hA0);
      settle();
      `CHK("am_on2", 1'b1, mc.regulator_am_on)
      `CHK("idx_a", 4'hA, mc.amplitude_index_field)
      `CHK("lvl0", 7'h00, mc.resistive_modulated_level)
      `CHK("shp_off", 1'b0, mc.shaped_regulator_modulation_enable)
      `CHK("drv_off", 1'b0, mc.driver_loadmod_enable)
   endtask

   // Same offset in both spaces must stay apart; an unmapped place reads zero.
   task automatic t_space();
      logic [7:0] d;
      wr(1'b1, 8'h28, 8'h34);
      rd(1'b0, 8'h28, d);
      `CHK("tx_kept", 8'hA0, d)
      @(posedge clk);
      #1;
      `CHK("rdata_idle", 8'h00, reg_rdata)
      rd(1'b1, 8'h28, d);
      `CHK("aux_34", 8'h34, d)
      wr(1'b1, 8'h29, 8'h55);
      rd(1'b1, 8'h29, d);
      `CHK("unmapped", 8'h00, d)
   endtask

   // A write while the clock enable is low must not land anywhere.
   task automatic t_freeze();
      logic [7:0] d;
      ce <= 1'b0;
      wr(1'b1, 8'h28, 8'hC8);
      ce <= 1'b1;
      rd(1'b1, 8'h28, d);
      `CHK("frozen", 8'h34, d)
   endtask

   // Reset in mid run brings the passive target and auxiliary registers back to their reset values.
   task automatic t_midreset();
      logic [7:0] d;
      wr(1'b0, 8'h29, 8'h21);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(1'b0, 8'h29, d);
      `CHK("pt_rst", 8'h70, d)
      rd(1'b1, 8'h28, d);
      `CHK("aux_rst", 8'h10, d)
      settle();
      `CHK("drv_rst", 1'b1, mc.driver_loadmod_enable)
   endtask

   // Every polarity, enable and modulation state of the external pin.
   task automatic t_pin();
      logic [2:0] k;
      for (int i = 0; i < 8; i++) begin
         k = i[2:0];
         wr(1'b1, 8'h28, {1'b0, k[2], k[1], 5'h10});
         loadmod_active <= k[0];
         settle();
         `CHK("pin", (k[1] & k[0]) ^ k[2], pin)
      end
   endtask

   // Modulated state picks the high field, including the high impedance code.
   task automatic t_res();
      wr(1'b0, 8'h29, 8'hF3);
      wr(1'b1, 8'h28, 8'h10);
      loadmod_active <= 1'b1;
      settle();
      `CHK("res_mod", 4'hF, mc.rf_output_driver_res)
      `CHK("hiz", 1'b1, mc.rf_output_driver_high_z)
      loadmod_active <= 1'b0;
      settle();
      `CHK("res_unm", 4'h3, mc.rf_output_driver_res)
      `CHK("hiz0", 1'b0, mc.rf_output_driver_high_z)
      wr(1'b0, 8'h29, 8'hE3);
      wr(1'b1, 8'h28, 8'h00);
      loadmod_active <= 1'b1;
      settle();
      `CHK("res_drvoff", 4'h3, mc.rf_output_driver_res)
      wr(1'b1, 8'h28, 8'h10);
      settle();
      `CHK("res_e", 4'hE, mc.rf_output_driver_res)
      `CHK("hiz_e", 1'b0, mc.rf_output_driver_high_z)
   endtask

   // Counts and verdict; the only place the run ends.
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Main sequence after a five cycle reset.
   initial begin
      failures = 0;
      tests_run = 0;
      rst = 1'b1;
      ce = 1'b1;
      reg_space = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      res_level = 7'h5A;
      loadmod_active = 1'b0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_aux();
      t_space();
      t_freeze();
      t_midreset();
      t_pin();
      t_res();
      report_and_stop();
   end

   // Watchdog sized well beyond the hundred or so cycles the tests need.
   initial begin
      #200us;
      failures++;
      report_and_stop();
   end
endmodule
